// ==== src/mrse_defs.svh ====
// timing counts, register count and reset values for the move/return/sleep executor
// assumes inclusion by bare name from the executor module
// Function
// - copy file reg to accumulator if selector 0, else back to itself
// - copy file reg updates zero flag from moved value only
// - load literal puts 8-bit immediate in accumulator, flags untouched
// - store accumulator writes accumulator to indexed file reg, flags untouched
// - return with literal loads accumulator, pops stack into program counter
// - return with literal takes two instruction cycles
// - rotate left through carry, result to accumulator or register, carry only
// - sleep clears watchdog count and watchdog prescaler
// - sleep clears power-down flag n and sets expiry flag n only
// - after sleep the core enters sleep with oscillator halted
`ifndef MRSE_DEFS_SVH
`define MRSE_DEFS_SVH
`define MRSE_ACC_RST 8'h00
`define MRSE_PC_RST 13'h0000
`define MRSE_RET_CYCLES 2
`define MRSE_REG_COUNT 128
`endif

// ==== src/mrse_pkg.sv ====
// types of the move/return/sleep executor
// assumes the defines header is compiled with it
package mrse_pkg;
   typedef enum logic [3:0] {
      MRSE_OP_NOP,
      MRSE_OP_COPY,
      MRSE_OP_LIT,
      MRSE_OP_STORE,
      MRSE_OP_RETLIT,
      MRSE_OP_ROT,
      MRSE_OP_RETIRQ,
      MRSE_OP_SLEEP
   } mrse_op_t;
   typedef enum logic [1:0] {
      MRSE_ST_RUN,
      MRSE_ST_FLUSH,
      MRSE_ST_SLEEP
   } mrse_state_t;
endpackage

// ==== src/mrse_exec.sv ====
// executor for copy, literal, store, rotate, nop, returns and sleep
// assumes a decoded op with operands each cycle while READY is high; wake from outside
`timescale 1ns/1ps
`include "mrse_defs.svh"
module mrse_exec
   import mrse_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic OP_VALID,
   input wire mrse_op_t OP_CODE,
   input wire logic [6:0] OP_FILE,
   input wire logic OP_DEST,
   input wire logic [7:0] OP_LIT,
   input wire logic [12:0] STACK_HEAD,
   input wire logic WAKE,
   output logic READY,
   output logic STACK_POP,
   output logic [7:0] ACC,
   output logic [12:0] PC,
   output logic ZERO_FLAG,
   output logic CARRY_FLAG,
   output logic GLOBAL_IRQ_ENABLE,
   output logic EXPIRY_FLAG_N,
   output logic POWER_DOWN_FLAG_N,
   output logic WDT_CLEAR,
   output logic OSC_HALT,
   output logic [7:0] FILE_Q0
);
   // ****************************************
   // storage and state
   // ****************************************
   logic [7:0] file_mem [0:`MRSE_REG_COUNT-1];
   mrse_state_t state;
   mrse_state_t next_state;
   logic [7:0] acc;
   logic [12:0] pc;
   logic zf, cf, global_irq_enable, to_n, pd_n;

   // ****************************************
   // decode
   // ****************************************
   wire logic go = OP_VALID && (state == MRSE_ST_RUN);
   wire logic [7:0] fval = file_mem[OP_FILE];
   wire logic [7:0] rot_val = {fval[6:0], cf};
   wire logic is_copy = go && OP_CODE == MRSE_OP_COPY;
   wire logic is_rot = go && OP_CODE == MRSE_OP_ROT;
   wire logic is_ret = go && (OP_CODE == MRSE_OP_RETLIT || OP_CODE == MRSE_OP_RETIRQ);
   wire logic is_sleep = go && OP_CODE == MRSE_OP_SLEEP;
   wire logic to_acc = (is_copy || is_rot) && !OP_DEST;
   wire logic to_file = ((is_copy || is_rot) && OP_DEST) || (go && OP_CODE == MRSE_OP_STORE);
   wire logic [7:0] file_wd = is_rot ? rot_val : (is_copy ? fval : acc);

   always_comb begin
      next_state = state;
      case (state)
         MRSE_ST_RUN: begin
            if (is_ret) begin
               next_state = MRSE_ST_FLUSH;
            end else if (is_sleep) begin
               next_state = MRSE_ST_SLEEP;
            end
         end
         MRSE_ST_FLUSH: next_state = MRSE_ST_RUN;
         MRSE_ST_SLEEP: begin
            if (WAKE) begin
               next_state = MRSE_ST_RUN;
            end
         end
         default: next_state = MRSE_ST_RUN;
      endcase
   end

   assign READY = (state == MRSE_ST_RUN);
   assign STACK_POP = is_ret;
   assign WDT_CLEAR = is_sleep;
   assign OSC_HALT = (state == MRSE_ST_SLEEP);
   assign ACC = acc;
   assign PC = pc;
   assign ZERO_FLAG = zf;
   assign CARRY_FLAG = cf;
   assign GLOBAL_IRQ_ENABLE = global_irq_enable;
   assign EXPIRY_FLAG_N = to_n;
   assign POWER_DOWN_FLAG_N = pd_n;
   assign FILE_Q0 = file_mem[0];

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= MRSE_ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         acc <= `MRSE_ACC_RST;
      end else if (to_acc) begin
         acc <= is_rot ? rot_val : fval;
      end else if (go && (OP_CODE == MRSE_OP_LIT || OP_CODE == MRSE_OP_RETLIT)) begin
         acc <= OP_LIT;
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pc <= `MRSE_PC_RST;
      end else if (is_ret) begin
         pc <= STACK_HEAD;
      end else if (go && !is_sleep) begin
         pc <= pc + 13'h0001;
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         zf <= 1'b0;
         cf <= 1'b0;
         global_irq_enable <= 1'b0;
         to_n <= 1'b1;
         pd_n <= 1'b1;
      end else begin
         if (is_copy) begin
            zf <= (fval == 8'h00);
         end
         if (is_rot) begin
            cf <= fval[7];
         end
         if (go && OP_CODE == MRSE_OP_RETIRQ) begin
            global_irq_enable <= 1'b1;
         end
         if (is_sleep) begin
            to_n <= 1'b1;
            pd_n <= 1'b0;
         end
      end
   end

   // file memory has no reset: contents are undefined until written
   always_ff @(posedge CORE_CLK) begin
      if (to_file) begin
         file_mem[OP_FILE] <= file_wd;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_ret_issue;
      is_ret;
   endsequence
   sequence s_ret_done;
      !READY ##1 READY;
   endsequence

   chk_ret_two_cycles: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      s_ret_issue |=> s_ret_done) else $error("return did not take two cycles");
   chk_ret_pc_load: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_ret |=> PC == $past(STACK_HEAD)) else $error("pc not loaded from stack head");
   chk_lit_flags: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_LIT |=> ACC == $past(OP_LIT) && $stable({zf, cf}))
      else $error("literal load wrong");
   chk_copy_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_copy |=> ZERO_FLAG == ($past(fval) == 8'h00) && $stable(cf))
      else $error("copy zero flag wrong");
   chk_copy_acc: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_copy && !OP_DEST |=> ACC == $past(fval)) else $error("copy to acc wrong");
   chk_rot_carry: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_rot |=> CARRY_FLAG == $past(fval[7]) && $stable(zf)) else $error("rotate carry wrong");
   chk_store_flags: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_STORE |=> $stable({zf, cf, ACC})) else $error("store changed flags");
   chk_sleep_flags: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_sleep |=> !POWER_DOWN_FLAG_N && EXPIRY_FLAG_N && OSC_HALT && $stable({zf, cf}))
      else $error("sleep flags wrong");
   chk_sleep_wdt: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      WDT_CLEAR |-> is_sleep && READY) else $error("stray watchdog clear");
   chk_irq_enable: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_RETIRQ |=> GLOBAL_IRQ_ENABLE && $stable(zf))
      else $error("irq enable not set");
   chk_nop_only_pc: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_NOP |=> PC == $past(PC) + 13'h0001 && $stable({ACC, zf, cf, global_irq_enable}))
      else $error("nop changed state");

   // ****************************************
   // checks of kept state and sleep
   // ****************************************
   sequence s_sleep_issue;
      is_sleep;
   endsequence
   sequence s_halted;
      !READY && OSC_HALT;
   endsequence
   sequence s_woken;
      READY && !OSC_HALT;
   endsequence

   chk_rot_acc: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_rot && !OP_DEST
      |=> ACC == {$past(fval[6:0]), $past(cf)})
      else $error("rotate to acc wrong");

   chk_rot_dest_file: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_rot && OP_DEST
      |=> $stable(ACC) && $stable(ZERO_FLAG))
      else $error("rotate to file changed acc");

   chk_copy_dest_file: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_copy && OP_DEST
      |=> $stable(ACC) && $stable(CARRY_FLAG))
      else $error("copy to file changed acc");

   chk_store_q0: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_STORE && OP_FILE == 7'h00
      |=> FILE_Q0 == $past(ACC))
      else $error("store did not land");

   chk_retlit_acc: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_RETLIT
      |=> ACC == $past(OP_LIT) && $stable({ZERO_FLAG, CARRY_FLAG}))
      else $error("return literal acc wrong");

   chk_retirq_pc: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_RETIRQ
      |=> PC == $past(STACK_HEAD) && $stable(ACC))
      else $error("irq return pc wrong");

   chk_ret_pop: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      STACK_POP
      |-> READY && OP_VALID)
      else $error("stray stack pop");

   chk_flush_quiet: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      !READY
      |=> $stable(PC) && $stable(ACC))
      else $error("op taken while not ready");

   chk_sleep_pc: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_sleep
      |=> $stable(PC))
      else $error("sleep advanced pc");

   chk_sleep_enter: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      s_sleep_issue
      |=> s_halted)
      else $error("sleep not entered");

   chk_sleep_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      OSC_HALT && !WAKE
      |=> s_halted)
      else $error("sleep left without wake");

   chk_wake_run: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      OSC_HALT && WAKE
      |=> s_woken)
      else $error("wake did not resume");

   chk_halt_quiet: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      OSC_HALT
      |-> !STACK_POP && !WDT_CLEAR)
      else $error("activity while halted");

   chk_sleep_keep: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      is_sleep
      |=> $stable(GLOBAL_IRQ_ENABLE) && $stable(ACC))
      else $error("sleep changed other state");

   chk_lit_pc: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_LIT
      |=> PC == $past(PC) + 13'h0001)
      else $error("literal pc step wrong");

   chk_store_pc: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_STORE
      |=> PC == $past(PC) + 13'h0001)
      else $error("store pc step wrong");

   chk_nop_file: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      go && OP_CODE == MRSE_OP_NOP
      |=> $stable(FILE_Q0) && $stable({EXPIRY_FLAG_N, POWER_DOWN_FLAG_N}))
      else $error("nop changed memory");

   chk_expiry_kept: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      !is_sleep
      |=> $stable(EXPIRY_FLAG_N))
      else $error("expiry flag moved");

   chk_pd_kept: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      !is_sleep
      |=> $stable(POWER_DOWN_FLAG_N))
      else $error("power down flag moved");

   chk_gie_kept: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      !(go && OP_CODE == MRSE_OP_RETIRQ)
      |=> $stable(GLOBAL_IRQ_ENABLE))
      else $error("irq enable moved");

   chk_carry_kept: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      !is_rot
      |=> $stable(CARRY_FLAG))
      else $error("carry moved");

   chk_zero_kept: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      !is_copy
      |=> $stable(ZERO_FLAG))
      else $error("zero flag moved");
endmodule

// ==== verif/tb_mrse_exec.sv ====
// testbench of the move/return/sleep executor: driver notes, monitor compares
// assumes the executor module, its package and the defines header
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb_mrse_exec
   import mrse_pkg::*;
;
   // ************
   // stimulus and model
   // ************
   logic CORE_CLK = 0, ARST_N = 0, OP_VALID = 0, OP_DEST = 0, WAKE = 0;
   mrse_op_t OP_CODE = MRSE_OP_NOP;
   logic [6:0] OP_FILE = 0;
   logic [7:0] OP_LIT = 0;
   logic [12:0] STACK_HEAD = 0;
   logic READY, STACK_POP, ZERO_FLAG, CARRY_FLAG, GLOBAL_IRQ_ENABLE;
   logic EXPIRY_FLAG_N, POWER_DOWN_FLAG_N, WDT_CLEAR, OSC_HALT;
   logic [7:0] ACC, FILE_Q0;
   logic [12:0] PC;
   logic [7:0] mem [128];
   logic [7:0] acc = 0;
   logic [12:0] pc = 0;
   logic z = 0, cy = 0, global_irq_enable = 0, ton = 1, pdn = 1, dead = 0, slp = 0, pop = 0, wdt = 0;
   logic [1:0] pp = 0;
   logic [37:0] q [$];
   logic [37:0] ex;
   int n_fail = 0, num_checks = 0, cyc = 0;
   mrse_op_t c;
   mrse_exec mrse_exec_inst (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .OP_VALID(OP_VALID),
      .OP_CODE(OP_CODE), .OP_FILE(OP_FILE), .OP_DEST(OP_DEST), .OP_LIT(OP_LIT),
      .STACK_HEAD(STACK_HEAD), .WAKE(WAKE), .READY(READY), .STACK_POP(STACK_POP), .ACC(ACC),
      .PC(PC), .ZERO_FLAG(ZERO_FLAG), .CARRY_FLAG(CARRY_FLAG),
      .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .EXPIRY_FLAG_N(EXPIRY_FLAG_N),
      .POWER_DOWN_FLAG_N(POWER_DOWN_FLAG_N), .WDT_CLEAR(WDT_CLEAR), .OSC_HALT(OSC_HALT),
      .FILE_Q0(FILE_Q0));
   initial begin
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end
   task automatic note();
      q.push_back({!(dead || slp), slp, acc, pc, z, cy, global_irq_enable, ton, pdn, mem[0], pop, wdt});
   endtask
   task automatic op(mrse_op_t oc, logic [6:0] f, logic d, logic [7:0] k);
      logic [7:0] v, r;
      logic [12:0] h;
      h = 13'($urandom);
      OP_VALID <= 1;
      OP_CODE <= oc;
      OP_FILE <= f;
      OP_DEST <= d;
      OP_LIT <= k;
      STACK_HEAD <= h;
      @(posedge CORE_CLK);
      v = mem[f];
      pop = 0;
      wdt = 0;
      if (!dead && !slp) begin
         pc = pc + 13'h0001;
         case (oc)
            MRSE_OP_COPY: begin if (!d) acc = v; z = (v == 8'h00); end
            MRSE_OP_LIT: acc = k;
            MRSE_OP_STORE: mem[f] = acc;
            MRSE_OP_ROT: begin r = {v[6:0], cy}; cy = v[7]; if (d) mem[f] = r; else acc = r; end
            MRSE_OP_RETLIT: begin acc = k; pc = h; dead = 1; pop = 1; end
            MRSE_OP_RETIRQ: begin pc = h; global_irq_enable = 1; dead = 1; pop = 1; end
            MRSE_OP_SLEEP: begin pc = pc - 13'h0001; ton = 1; pdn = 0; slp = 1; wdt = 1; end
            default: ;
         endcase
      end else dead = 0;
      note();
   endtask
   task automatic wake_up();
      OP_VALID <= 0;
      WAKE <= 1;
      @(posedge CORE_CLK);
      WAKE <= 0;
      slp = 0;
      pop = 0;
      wdt = 0;
      note();
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(negedge CORE_CLK) begin
      if (q.size() > 0) begin
         ex = q.pop_front();
         `CHK({READY, OSC_HALT, ACC, PC, ZERO_FLAG, CARRY_FLAG, GLOBAL_IRQ_ENABLE, EXPIRY_FLAG_N,
            POWER_DOWN_FLAG_N, FILE_Q0, pp}, ex)
      end
      pp = {STACK_POP, WDT_CLEAR};
   end
   always @(posedge CORE_CLK) begin
      cyc++;
      if (cyc == 5000) begin n_fail++; close_out(); end
   end
   initial begin
      void'($urandom(32'haa0a68ba));
      repeat (10) @(posedge CORE_CLK);
      ARST_N <= 1;
      op(MRSE_OP_STORE, 7'h00, 0, 8'h00);
      for (int i = 1; i < 128; i++) begin
         op(MRSE_OP_LIT, 7'h00, 0, 8'($urandom));
         op(MRSE_OP_STORE, 7'(i), 0, 8'h00);
      end
      op(MRSE_OP_COPY, 7'h00, 1, 8'h00);
      for (int n = 0; n < 400; n++) begin
         c = mrse_op_t'($urandom_range(0, 7));
         op(c, 7'($urandom_range(0, 3) == 0 ? 0 : $urandom), 1'($urandom), 8'($urandom));
         if (c == MRSE_OP_SLEEP) begin
            op(MRSE_OP_NOP, 7'h00, 0, 8'h00);
            wake_up();
         end
      end
      OP_VALID <= 0;
      repeat (3) @(posedge CORE_CLK);
      close_out();
   end
endmodule
